// ===== verilog/timer_compare_register_block.sv
// Implementation choice: the Wishbone interface to the registers.
module timer_compare_register_block (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt
    output logic             irq_o
);

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic ch_hit(input logic [11:0] adr, input logic [11:0] base, input int idx);
        logic [9:0] word;
        word = base[11:2] + idx[9:0];
        return adr[11:2] == word;
    endfunction : ch_hit

    // Word decode; address bits 1:0 never select a register
    function automatic logic reg_hit(input logic [11:0] adr, input logic [11:0] ofs);
        return adr[11:2] == ofs[11:2];
    endfunction : reg_hit

    function automatic logic [31:0] width_mask(input logic [1:0] w);
        logic [31:0] m;
        m = 32'h0000FFFF;
        unique case (w)
            timer_pkg::WIDTH_16: m = 32'h0000FFFF;
            timer_pkg::WIDTH_8:  m = 32'h000000FF;
            timer_pkg::WIDTH_24: m = 32'h00FFFFFF;
            timer_pkg::WIDTH_32: m = 32'hFFFFFFFF;
        endcase
        return m;
    endfunction : width_mask

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ************************************************************
    // State
    // ************************************************************
    logic                                ack_q;
    logic [31:0]                         rdata_q;
    logic                                irq_q;
    logic                                running_q;
    logic [31:0]                         counter_q;
    logic [timer_pkg::PRE_W-1:0]         pre_q;
    logic                                inc_q;
    logic [timer_pkg::NUM_CH-1:0]        event_q;
    logic [timer_pkg::NUM_CH-1:0]        status_q;
    logic [timer_pkg::NUM_CH-1:0]        ien_q;
    logic [timer_pkg::LINK_W-1:0]        links_q;
    logic [timer_pkg::MODE_W-1:0]        mode_q;
    logic [timer_pkg::WIDTH_W-1:0]       width_q;
    logic [timer_pkg::DIV_W-1:0]         div_q;
    logic [31:0]                         match_q [timer_pkg::NUM_CH];

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic                                req;
    logic                                wr;
    logic                                rd;
    logic                                task_bit;
    logic                                start_task;
    logic                                stop_task;
    logic                                count_task;
    logic                                clear_task;
    logic [timer_pkg::NUM_CH-1:0]        capture_task;
    logic [timer_pkg::NUM_CH-1:0]        event_wr;
    logic [timer_pkg::NUM_CH-1:0]        match_wr;
    logic                                status_rd;
    logic                                links_wr;
    logic                                mode_wr;
    logic                                width_wr;
    logic                                div_wr;
    logic                                ien_set_wr;
    logic                                ien_clr_wr;

    always_comb begin
        req        = wb_cyc_i & wb_stb_i & ~ack_q;
        wr         = req & wb_we_i;
        rd         = req & ~wb_we_i;
        task_bit   = wb_sel_i[0] & wb_dat_i[0];
        start_task = wr & task_bit & reg_hit(wb_adr_i, timer_pkg::OFS_START);
        stop_task  = wr & task_bit & reg_hit(wb_adr_i, timer_pkg::OFS_STOP);
        count_task = wr & task_bit & reg_hit(wb_adr_i, timer_pkg::OFS_COUNT);
        clear_task = wr & task_bit & reg_hit(wb_adr_i, timer_pkg::OFS_CLEAR);
        status_rd  = rd & reg_hit(wb_adr_i, timer_pkg::OFS_STATUS);
        links_wr   = wr & reg_hit(wb_adr_i, timer_pkg::OFS_LINKS);
        mode_wr    = wr & wb_sel_i[0] & reg_hit(wb_adr_i, timer_pkg::OFS_MODE);
        width_wr   = wr & wb_sel_i[0] & reg_hit(wb_adr_i, timer_pkg::OFS_WIDTH);
        div_wr     = wr & wb_sel_i[0] & reg_hit(wb_adr_i, timer_pkg::OFS_DIVIDER);
        ien_set_wr = wr & wb_sel_i[0] & reg_hit(wb_adr_i, timer_pkg::OFS_IEN_SET);
        ien_clr_wr = wr & wb_sel_i[0] & reg_hit(wb_adr_i, timer_pkg::OFS_IEN_CLR);
        for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
            capture_task[c] = wr & task_bit & ch_hit(wb_adr_i, timer_pkg::OFS_CAPTURE, c);
            event_wr[c]     = wr & wb_sel_i[0] & ch_hit(wb_adr_i, timer_pkg::OFS_EVENT, c);
            match_wr[c]     = wr & ch_hit(wb_adr_i, timer_pkg::OFS_MATCH, c);
        end
    end

    // ************************************************************
    // Compare and links
    // ************************************************************
    logic [31:0]                         mask;
    logic [timer_pkg::NUM_CH-1:0]        hit;
    logic                                clear_now;
    logic                                stop_now;
    logic [timer_pkg::PRE_W-1:0]         pre_limit;
    logic                                tick;

    always_comb begin
        mask = width_mask(width_q);
        for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
            // Only a fresh counter value can match, so a stopped counter raises nothing
            hit[c] = inc_q & ((counter_q & mask) == (match_q[c] & mask));
        end
        clear_now = clear_task
                  | (|(hit & links_q[timer_pkg::LINK_CLEAR_LSB +: timer_pkg::NUM_CH]));
        stop_now  = stop_task
                  | (|(hit & links_q[timer_pkg::LINK_STOP_LSB +: timer_pkg::NUM_CH]));
        pre_limit = timer_pkg::PRE_W'((16'h0001 << div_q) - 16'h0001);
        if (mode_q == timer_pkg::MODE_TIMER) begin
            tick = running_q & (pre_q == pre_limit);
        end else begin
            // Counter and lean modes advance only on the count task
            tick = running_q & count_task & ((mode_q == timer_pkg::MODE_COUNTER)
                                            | (mode_q == timer_pkg::MODE_LEAN));
        end
    end

    // ************************************************************
    // Run control
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            running_q <= 1'b0;
        end else if (stop_now) begin
            running_q <= 1'b0;
        end else if (start_task) begin
            running_q <= 1'b1;
        end
    end

    // ************************************************************
    // Prescaler and counter
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pre_q <= '0;
        end else if (!running_q || clear_now || pre_q == pre_limit) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + timer_pkg::PRE_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            counter_q <= '0;
            inc_q     <= 1'b0;
        end else begin
            inc_q <= tick & ~clear_now;
            if (clear_now) begin
                counter_q <= '0;
            end else if (tick) begin
                counter_q <= (counter_q + 32'h00000001) & mask;
            end
        end
    end

    // ************************************************************
    // Events and status
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            event_q <= '0;
        end else begin
            for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
                // Hardware set wins over a software clear in the same cycle
                if (hit[c]) begin
                    event_q[c] <= 1'b1;
                end else if (event_wr[c]) begin
                    event_q[c] <= wb_dat_i[0];
                end
            end
        end
    end

    // A match in the clearing read's cycle stays visible
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_q <= '0;
        end else begin
            for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
                if (hit[c]) begin
                    status_q[c] <= 1'b1;
                end else if (status_rd) begin
                    status_q[c] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ien_q <= '0;
        end else if (ien_set_wr) begin
            ien_q <= ien_q | wb_dat_i[timer_pkg::NUM_CH-1:0];
        end else if (ien_clr_wr) begin
            ien_q <= ien_q & ~wb_dat_i[timer_pkg::NUM_CH-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            links_q <= timer_pkg::LINKS_RST;
        end else if (links_wr) begin
            links_q <= timer_pkg::LINK_W'(merge({20'h00000, links_q}, wb_dat_i, wb_sel_i));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_q <= timer_pkg::MODE_RST;
        end else if (mode_wr) begin
            mode_q <= wb_dat_i[timer_pkg::MODE_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            width_q <= timer_pkg::WIDTH_RST;
        end else if (width_wr) begin
            width_q <= wb_dat_i[timer_pkg::WIDTH_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_q <= timer_pkg::DIVIDER_RST;
        end else if (div_wr) begin
            div_q <= wb_dat_i[timer_pkg::DIV_W-1:0];
        end
    end

    // ************************************************************
    // Capture/compare values
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
                match_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
                // Capture beats a bus write to the same channel
                if (capture_task[c]) begin
                    match_q[c] <= counter_q;
                end else if (match_wr[c]) begin
                    match_q[c] <= merge(match_q[c], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    // ************************************************************
    // Read back and acknowledge
    // ************************************************************
    logic [31:0] rmux;

    always_comb begin
        rmux = 32'h00000000;
        unique case (wb_adr_i[11:2])
            timer_pkg::OFS_LINKS[11:2]:   rmux = {20'h00000, links_q};
            timer_pkg::OFS_IEN_SET[11:2]: rmux = {26'h0000000, ien_q};
            timer_pkg::OFS_IEN_CLR[11:2]: rmux = {26'h0000000, ien_q};
            timer_pkg::OFS_MODE[11:2]:    rmux = {30'h00000000, mode_q};
            timer_pkg::OFS_WIDTH[11:2]:   rmux = {30'h00000000, width_q};
            timer_pkg::OFS_DIVIDER[11:2]: rmux = {28'h0000000, div_q};
            timer_pkg::OFS_STATUS[11:2]:  rmux = {26'h0000000, status_q};
            default:                      rmux = 32'h00000000;
        endcase
        for (int c = 0; c < timer_pkg::NUM_CH; c++) begin
            if (ch_hit(wb_adr_i, timer_pkg::OFS_EVENT, c)) begin
                rmux = {31'h00000000, event_q[c]};
            end
            if (ch_hit(wb_adr_i, timer_pkg::OFS_MATCH, c)) begin
                rmux = match_q[c];
            end
        end
    end

    // Every address answers; unmapped ones read zero and drop writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= req;
            if (rd) begin
                rdata_q <= rmux;
            end
        end
    end

    // ************************************************************
    // Interrupt
    // ************************************************************
    // One cycle behind status, the price of a flop-driven output
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & ien_q);
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign irq_o    = irq_q;

endmodule : timer_compare_register_block

// ===== verilog/timer_pkg.sv
package timer_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int          NUM_CH          = 6;
    localparam int          ADR_W           = 12;
    localparam int          LINK_CLEAR_LSB  = 0;
    localparam int          LINK_STOP_LSB   = 6;
    localparam int          LINK_W          = 12;
    localparam int          MODE_W          = 2;
    localparam int          WIDTH_W         = 2;
    localparam int          DIV_W           = 4;
    localparam int          PRE_W           = 15;

    // ************************************************************
    // Byte offsets
    // ************************************************************
    localparam logic [11:0] OFS_START       = 12'h000;
    localparam logic [11:0] OFS_STOP        = 12'h004;
    localparam logic [11:0] OFS_COUNT       = 12'h008;
    localparam logic [11:0] OFS_CLEAR       = 12'h00C;
    localparam logic [11:0] OFS_CAPTURE     = 12'h040;
    localparam logic [11:0] OFS_EVENT       = 12'h140;
    localparam logic [11:0] OFS_LINKS       = 12'h200;
    localparam logic [11:0] OFS_IEN_SET     = 12'h304;
    localparam logic [11:0] OFS_IEN_CLR     = 12'h308;
    localparam logic [11:0] OFS_MODE        = 12'h504;
    localparam logic [11:0] OFS_WIDTH       = 12'h508;
    localparam logic [11:0] OFS_DIVIDER     = 12'h510;
    localparam logic [11:0] OFS_MATCH       = 12'h540;
    localparam logic [11:0] OFS_STATUS      = 12'h600;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [1:0]  MODE_TIMER      = 2'h0;
    localparam logic [1:0]  MODE_COUNTER    = 2'h1;
    localparam logic [1:0]  MODE_LEAN       = 2'h2;
    localparam logic [1:0]  WIDTH_16        = 2'h0;
    localparam logic [1:0]  WIDTH_8         = 2'h1;
    localparam logic [1:0]  WIDTH_24        = 2'h2;
    localparam logic [1:0]  WIDTH_32        = 2'h3;
    localparam logic [1:0]  MODE_RST        = 2'h0;
    localparam logic [1:0]  WIDTH_RST       = 2'h0;
    localparam logic [3:0]  DIVIDER_RST     = 4'h4;
    localparam logic [11:0] LINKS_RST       = 12'h000;

endpackage : timer_pkg

// ===== verification/timer_monitor.sv
module timer_monitor (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // Wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Interrupt
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // Helpers
    // ************************************************************
    logic take;
    logic rd;
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd   = take & ~wb_we_i;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ************************************************************
    // Properties
    // ************************************************************
    a_ack_after_take: assert property (take |=> wb_ack_o)
        else $error("no ack one cycle after a taken request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(take))
        else $error("ack without a request");
    // Own disable: this one must hold while reset is high
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !wb_ack_o && !irq_o && wb_dat_o == 32'h0)
        else $error("outputs not quiet after reset");
    a_read_data_holds: assert property (!rd |=> $stable(wb_dat_o))
        else $error("read data changed without a read");
    a_unmapped_reads_zero: assert property (rd && wb_adr_i[11:2] == 10'h1FF |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_enable_field_only: assert property (rd && wb_adr_i[11:2] inside {10'h0C1, 10'h0C2}
        |=> wb_dat_o[31:6] == 26'h0)
        else $error("enable read has upper bits set");
    a_mode_field_only: assert property (rd && wb_adr_i[11:2] == 10'h141 |=> wb_dat_o[31:2] == 30'h0)
        else $error("mode read has upper bits set");
    a_width_field_only: assert property (rd && wb_adr_i[11:2] == 10'h142 |=> wb_dat_o[31:2] == 30'h0)
        else $error("width read has upper bits set");
    a_divider_field_only: assert property (rd && wb_adr_i[11:2] == 10'h144 |=> wb_dat_o[31:4] == 28'h0)
        else $error("divider read has upper bits set");
    a_irq_off_disabled: assert property (take && wb_we_i && wb_adr_i[11:2] == 10'h0C2 && wb_sel_i[0]
        && wb_dat_i[5:0] == 6'h3F |-> ##2 !irq_o)
        else $error("interrupt still high after all disabled");

    c_status_read: cover property (rd && wb_adr_i[11:2] == 10'h180);
    c_irq_rise: cover property ($rose(irq_o));
    c_links_write: cover property (take && wb_we_i && wb_adr_i[11:2] == 10'h080);
endmodule : timer_monitor

bind timer_compare_register_block timer_monitor mon (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o);

// ===== verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // Signals
    // ************************************************************
    logic        ref_clk;
    logic        reset;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq_o;
    int          n_mismatch;
    int          checks;

    timer_compare_register_block uut (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o);

    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;

    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Waits for ack as long as it takes; only the watchdog ends a hang
    task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        bus(1'b1, adr, dat, q);
    endtask : wr

    task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, adr, 32'h0, q);
        check(q, exp);
    endtask : rd_chk

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_values();
        rd_chk(12'h200, 32'h0);
        rd_chk(12'h304, 32'h0);
        rd_chk(12'h308, 32'h0);
        rd_chk(12'h504, 32'h0);
        rd_chk(12'h508, 32'h0);
        rd_chk(12'h510, 32'h4);
        rd_chk(12'h140, 32'h0);
    endtask : t_reset_values

    task automatic t_fields();
        for (int i = 0; i < 4; i++) begin
            wr(12'h508, {30'h3FFFFFFF, 2'(i)});
            rd_chk(12'h508, 32'(i));
            if (i < 3) wr(12'h504, {30'h3FFFFFFF, 2'(i)});
            if (i < 3) rd_chk(12'h504, 32'(i));
        end
        wr(12'h510, 32'hFFFFFFF7);
        rd_chk(12'h510, 32'h7);
        wr(12'h200, 32'hFFFFFFFF);
        rd_chk(12'h200, 32'hFFF);
        wr(12'h7FC, 32'hFFFFFFFF);
        rd_chk(12'h7FC, 32'h0);
        wr(12'h200, 32'h0);
        wr(12'h504, 32'h0);
    endtask : t_fields

    task automatic t_enable();
        wr(12'h304, 32'h25);
        rd_chk(12'h304, 32'h25);
        rd_chk(12'h308, 32'h25);
        wr(12'h304, 32'h0);
        rd_chk(12'h304, 32'h25);
        wr(12'h308, 32'h21);
        rd_chk(12'h304, 32'h04);
        wr(12'h308, 32'h0);
        rd_chk(12'h308, 32'h04);
        wr(12'h308, 32'h3F);
    endtask : t_enable

    // Compare bits above the 8-bit width must be ignored
    task automatic t_compare_irq();
        wr(12'h508, 32'h1);
        wr(12'h510, 32'h0);
        wr(12'h540, 32'h110);
        wr(12'h00C, 32'h1);
        wr(12'h000, 32'h1);
        repeat (40) @(posedge ref_clk);
        wr(12'h004, 32'h1);
        check(32'(irq_o), 32'h0);
        rd_chk(12'h140, 32'h1);
        wr(12'h304, 32'h1);
        check(32'(irq_o), 32'h1);
        rd_chk(12'h600, 32'h1);
        check(32'(irq_o), 32'h0);
        wr(12'h140, 32'h0);
        rd_chk(12'h140, 32'h0);
        wr(12'h308, 32'h3F);
    endtask : t_compare_irq

    task automatic t_links();
        logic [31:0] v;
        wr(12'h508, 32'h0);
        wr(12'h544, 32'h20);
        wr(12'h200, 32'h80);
        wr(12'h00C, 32'h1);
        wr(12'h000, 32'h1);
        repeat (60) @(posedge ref_clk);
        wr(12'h048, 32'h1);
        bus(1'b0, 12'h548, 32'h0, v);
        check(32'(v == 32'h20 || v == 32'h21), 32'h1);
        wr(12'h54C, 32'h30);
        wr(12'h200, 32'h8);
        wr(12'h000, 32'h1);
        repeat (150) @(posedge ref_clk);
        wr(12'h050, 32'h1);
        bus(1'b0, 12'h550, 32'h0, v);
        check(32'(v <= 32'h30), 32'h1);
        wr(12'h004, 32'h1);
        wr(12'h200, 32'h0);
    endtask : t_links

    // Divider 2: one tick every four clocks, about 43 clocks run
    task automatic t_prescaler();
        logic [31:0] v;
        wr(12'h510, 32'h2);
        wr(12'h00C, 32'h1);
        wr(12'h000, 32'h1);
        repeat (40) @(posedge ref_clk);
        wr(12'h004, 32'h1);
        wr(12'h050, 32'h1);
        bus(1'b0, 12'h550, 32'h0, v);
        check(32'(v >= 32'h9 && v <= 32'hC), 32'h1);
    endtask : t_prescaler

    task automatic t_count_modes();
        for (int m = 1; m < 3; m++) begin
            wr(12'h504, 32'(m));
            wr(12'h00C, 32'h1);
            wr(12'h000, 32'h1);
            repeat (3) wr(12'h008, 32'h1);
            repeat (20) @(posedge ref_clk);
            wr(12'h004, 32'h1);
            wr(12'h054, 32'h1);
            rd_chk(12'h554, 32'h3);
        end
        wr(12'h504, 32'h0);
    endtask : t_count_modes

    // Second start lands on the edge where the stop link fires on a match at 2
    task automatic t_stop_wins();
        logic [31:0] v;
        wr(12'h510, 32'h0);
        wr(12'h554, 32'h2);
        wr(12'h200, 32'h800);
        wr(12'h00C, 32'h1);
        repeat (2) wr(12'h000, 32'h1);
        repeat (10) @(posedge ref_clk);
        wr(12'h050, 32'h1);
        bus(1'b0, 12'h550, 32'h0, v);
        check(32'(v <= 32'h3), 32'h1);
        wr(12'h200, 32'h0);
    endtask : t_stop_wins

    // ************************************************************
    // Run
    // ************************************************************
    task automatic summarize();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        n_mismatch = 0;
        checks = 0;
        reset = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset_values();
        t_fields();
        t_enable();
        t_compare_irq();
        t_links();
        t_prescaler();
        t_count_modes();
        t_stop_wins();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        summarize();
    end
endmodule : testbench
